// ---- core/fcp_pkg.sv ----
// Constants, types and register map of the flash protection controller
// Behaviour
// R1: Supply-low lock refuses work until clear-status
// R2: Engine failure sets program or erase fail
// R3: Reset during work keeps busy until done
// R4: Reset or power loss gives status 10000
// R5: Command front end holds last written command
// R6: Front end starts in read-array mode
// R7: Host writes read-array before expecting array data
// R8: Writes only with chip-select and strobe low
// R9: Array changes only after two-cycle sequence
// R10: Reset pin low disables all other inputs
// R11: Aborted work is reissued whole by host
// R12: Host waits wake-up intervals after reset release
// R13: Busy low after sequence, high when done
// R14: Busy high in erase suspend and power-down
// R15: Both fail flags mean bad erase sequence
// R16: Top status bit shows engine ready
// R17: Three low status bits read zero
package fcp_pkg;
    localparam int CLK_MHZ    = 250;
    // Times in ns
    localparam int WE_LOW_NS  = 60;
    localparam int RECOV_NS   = 40;
    localparam int ACCESS_NS  = 120;
    localparam int WHRL_NS    = 100;
    localparam int RST_LOW_NS = 100;
    localparam int WAKE_RD_NS = 400;
    localparam int WAKE_WR_NS = 1000;
    localparam int WAKE_NS    = (WAKE_RD_NS > WAKE_WR_NS) ? WAKE_RD_NS : WAKE_WR_NS;
    // Cycle counts, least times rounded up
    localparam logic [7:0] WE_LOW_CYC  = 8'((WE_LOW_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] RECOV_CYC   = 8'((RECOV_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] ACCESS_CYC  = 8'((ACCESS_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] WHRL_CYC    = 8'((WHRL_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] RST_LOW_CYC = 8'((RST_LOW_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] WAKE_CYC    = 8'((WAKE_NS * CLK_MHZ + 999) / 1000);
    // Device command codes
    localparam logic [7:0] CMD_ARRAY   = 8'hff;
    localparam logic [7:0] CMD_RSTAT   = 8'h70;
    localparam logic [7:0] CMD_CLEAR   = 8'h50;
    localparam logic [7:0] CMD_PROG    = 8'h40;
    localparam logic [7:0] CMD_ERASE   = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    // Device status bits
    localparam int SR_READY  = 7;
    localparam int SR_EFAIL  = 5;
    localparam int SR_PFAIL  = 4;
    localparam int SR_SUPPLY = 3;
    localparam logic [7:0] SR_USED_MASK = 8'hf8;
    localparam logic [7:0] SR_RESET     = 8'h80;
    // Controller register offsets
    localparam logic [7:0] REG_CMD      = 8'h00;
    localparam logic [7:0] REG_ADDR     = 8'h04;
    localparam logic [7:0] REG_WDATA    = 8'h08;
    localparam logic [7:0] REG_RDATA    = 8'h0c;
    localparam logic [7:0] REG_DEVSTAT  = 8'h10;
    localparam logic [7:0] REG_STATE    = 8'h14;
    localparam logic [7:0] REG_IRQ_ST   = 8'h18;
    localparam logic [7:0] REG_IRQ_MASK = 8'h1c;
    localparam logic [7:0] REG_PWR      = 8'h20;
    // Interrupt bits
    localparam int IRQ_W      = 5;
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_ERR    = 1;
    localparam int IRQ_LOCK   = 2;
    localparam int IRQ_REFUSE = 3;
    localparam int IRQ_ABORT  = 4;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

    typedef enum logic [2:0] {
        OP_READ   = 3'h0,
        OP_PROG   = 3'h1,
        OP_ERASE  = 3'h2,
        OP_CLEAR  = 3'h3,
        OP_STATUS = 3'h4
    } fcp_op_e;

    typedef struct packed {
        logic        ce_n;
        logic        we_n;
        logic        oe_n;
        logic [19:0] addr;
        logic [7:0]  dout;
        logic        doe;
    } fcp_pins_s;

    localparam fcp_pins_s PINS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                        addr: 20'h00000, dout: 8'h00, doe: 1'b0};
endpackage

// ---- core/fcp_cycle.sv ----
// Single read or write cycle on the flash pins
module fcp_cycle (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              start_i,
    input  wire logic              is_read_i,
    input  wire logic              abort_i,
    input  wire logic [19:0]       addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic [7:0]        data_i,
    output fcp_pkg::fcp_pins_s     pins_o,
    output logic                   done_o,
    output logic [7:0]             rdata_o
);
    import fcp_pkg::*;

    typedef enum logic [1:0] {
        C_IDLE   = 2'h0,
        C_SETUP  = 2'h1,
        C_STROBE = 2'h2,
        C_RECOV  = 2'h3
    } fcp_cyc_e;

    fcp_cyc_e   st;
    fcp_cyc_e   next_st;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic       rd;
    logic       next_rd;
    fcp_pins_s  next_pins;
    logic       next_done;
    logic [7:0] next_rdata;

    // Next values of the cycle sequencer
    always_comb begin
        next_st    = st;
        next_cnt   = cnt;
        next_rd    = rd;
        next_pins  = pins_o;
        next_done  = 1'b0;
        next_rdata = rdata_o;
        case (st)
            C_IDLE: begin
                if (start_i) begin
                    next_rd        = is_read_i;
                    next_pins.addr = addr_i;
                    next_pins.dout = wdata_i;
                    next_pins.doe  = !is_read_i;
                    next_pins.ce_n = 1'b0;
                    next_st        = C_SETUP;
                end
            end
            C_SETUP: begin
                if (rd) begin
                    next_pins.oe_n = 1'b0;
                    next_cnt       = ACCESS_CYC;
                end else begin
                    next_pins.we_n = 1'b0; // R8
                    next_cnt       = WE_LOW_CYC;
                end
                next_st = C_STROBE;
            end
            C_STROBE: begin
                next_cnt = cnt - 8'h01;
                if (cnt == 8'h01) begin
                    if (rd) begin
                        next_rdata = data_i;
                    end
                    next_pins.we_n = 1'b1;
                    next_pins.oe_n = 1'b1;
                    next_pins.ce_n = 1'b1; // R8
                    next_cnt       = RECOV_CYC;
                    next_st        = C_RECOV;
                end
            end
            C_RECOV: begin
                next_cnt = cnt - 8'h01;
                if (cnt == 8'h01) begin
                    next_pins.doe = 1'b0;
                    next_done     = 1'b1;
                    next_st       = C_IDLE;
                end
            end
            default: begin
                next_st = C_IDLE;
            end
        endcase
        if (abort_i) begin
            next_st   = C_IDLE;
            next_pins = PINS_IDLE;
            next_done = 1'b0;
        end
    end

    // Cycle sequencer registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st      <= C_IDLE;
            cnt     <= 8'h00;
            rd      <= 1'b0;
            pins_o  <= PINS_IDLE;
            done_o  <= 1'b0;
            rdata_o <= 8'h00;
        end else begin
            st      <= next_st;
            cnt     <= next_cnt;
            rd      <= next_rd;
            pins_o  <= next_pins;
            done_o  <= next_done;
            rdata_o <= next_rdata;
        end
    end
endmodule

// ---- core/fcp_top.sv ----
// Host controller sequencing program, erase, status and power-down on the flash
module fcp_top (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_b_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic [31:0]       reg_wdata_i,
    output logic [31:0]            reg_rdata_o,
    output logic                   irq_o,
    output fcp_pkg::fcp_pins_s     flash_o,
    input  wire logic [7:0]        flash_data_i,
    input  wire logic              ready_busy_n_i,
    output logic                   powerdown_reset_n_o
);
    import fcp_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE     = 4'h0,
        S_SETUP    = 4'h1,
        S_CONFIRM  = 4'h2,
        S_SETTLE   = 4'h3,
        S_WAIT_RDY = 4'h4,
        S_RD_STAT  = 4'h5,
        S_WR_ARRAY = 4'h6,
        S_RD_ARRAY = 4'h7,
        S_WR_CMD   = 4'h8,
        S_PD_HOLD  = 4'h9,
        S_WAKE     = 4'ha
    } fcp_state_e;

    logic [1:0]       rst_q;
    logic             rst_n;
    fcp_state_e       state;
    fcp_state_e       next_state;
    fcp_op_e          op_q;
    fcp_op_e          next_op;
    logic [7:0]       cnt;
    logic [7:0]       next_cnt;
    logic             pend;
    logic             next_pend;
    logic             lock;
    logic             next_lock;
    logic             seq_err;
    logic             next_seq_err;
    logic [7:0]       dev_stat;
    logic [7:0]       next_dev_stat;
    logic [7:0]       rbyte;
    logic [7:0]       next_rbyte;
    logic             next_pin_n;
    logic [IRQ_W-1:0] irq_set;
    logic             cyc_go;
    logic             cyc_rd;
    logic             cyc_bus;
    logic             cyc_abort;
    logic [7:0]       cyc_wdata;
    logic             cyc_done;
    logic [7:0]       cyc_rdata;
    logic             cmd_go;
    logic             is_pe;
    logic             op_live;
    logic [19:0]      addr_r;
    logic [7:0]       wdata_r;
    logic             pwr_req;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic [19:0]      next_addr;
    logic [7:0]       next_wdata;
    logic             next_pwr;
    logic [IRQ_W-1:0] next_irq_st;
    logic [IRQ_W-1:0] next_mask;
    logic [31:0]      next_rdata;

    // Reset release through two flops
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    assign cmd_go  = reg_wr_i && (reg_addr_i == REG_CMD);
    assign is_pe   = (op_q == OP_PROG) || (op_q == OP_ERASE);
    assign op_live = is_pe && (state != S_IDLE) && (state != S_PD_HOLD) && (state != S_WAKE);

    // Bus cycle request per state
    always_comb begin
        cyc_bus   = 1'b1;
        cyc_rd    = 1'b0;
        cyc_wdata = CMD_ARRAY;
        case (state)
            S_SETUP:    cyc_wdata = (op_q == OP_PROG) ? CMD_PROG : CMD_ERASE; // R9
            S_CONFIRM:  cyc_wdata = (op_q == OP_PROG) ? wdata_r : CMD_CONFIRM; // R9
            S_WR_CMD:   cyc_wdata = (op_q == OP_CLEAR) ? CMD_CLEAR : CMD_RSTAT;
            S_WR_ARRAY: cyc_wdata = CMD_ARRAY; // R7
            S_RD_STAT:  cyc_rd = 1'b1;
            S_RD_ARRAY: cyc_rd = 1'b1;
            default:    cyc_bus = 1'b0;
        endcase
        cyc_abort = pwr_req && (state != S_PD_HOLD) && (state != S_WAKE); // R10
        cyc_go    = cyc_bus && !pend && !cyc_abort;
    end

    fcp_cycle u_cycle (
        .clk_i     (clk_sys_i),
        .rst_n_i   (rst_n),
        .start_i   (cyc_go),
        .is_read_i (cyc_rd),
        .abort_i   (cyc_abort),
        .addr_i    (addr_r),
        .wdata_i   (cyc_wdata),
        .data_i    (flash_data_i),
        .pins_o    (flash_o),
        .done_o    (cyc_done),
        .rdata_o   (cyc_rdata)
    );

    // Operation sequencer next values
    always_comb begin
        next_state    = state;
        next_op       = op_q;
        next_cnt      = cnt;
        next_pend     = pend;
        next_lock     = lock;
        next_seq_err  = seq_err;
        next_dev_stat = dev_stat;
        next_rbyte    = rbyte;
        irq_set       = '0;
        if (cyc_go) begin
            next_pend = 1'b1;
        end
        if (cyc_done) begin
            next_pend = 1'b0;
        end
        if (cmd_go && (state != S_IDLE)) begin
            irq_set[IRQ_REFUSE] = 1'b1;
        end
        case (state)
            S_IDLE: begin
                if (cmd_go) begin
                    next_op = fcp_op_e'(reg_wdata_i[2:0]);
                    case (reg_wdata_i[2:0])
                        OP_READ:   next_state = S_RD_ARRAY;
                        OP_PROG,
                        OP_ERASE: begin
                            if (lock) begin
                                irq_set[IRQ_REFUSE] = 1'b1; // R1
                            end else begin
                                next_state = S_SETUP;
                            end
                        end
                        OP_CLEAR,
                        OP_STATUS: next_state = S_WR_CMD;
                        default:   irq_set[IRQ_REFUSE] = 1'b1;
                    endcase
                end
            end
            S_SETUP: begin
                if (cyc_done) begin
                    next_state = S_CONFIRM;
                end
            end
            S_CONFIRM: begin
                if (cyc_done) begin
                    next_cnt   = WHRL_CYC;
                    next_state = S_SETTLE;
                end
            end
            S_SETTLE: begin
                next_cnt = cnt - 8'h01;
                if (cnt == 8'h01) begin
                    next_state = S_WAIT_RDY;
                end
            end
            S_WAIT_RDY: begin
                if (ready_busy_n_i) begin // R13
                    next_state = S_RD_STAT;
                end
            end
            S_RD_STAT: begin
                if (cyc_done && cyc_rdata[SR_READY]) begin // R16
                    next_dev_stat = cyc_rdata & SR_USED_MASK; // R17
                    if (is_pe) begin
                        irq_set[IRQ_ERR] = cyc_rdata[SR_SUPPLY] | cyc_rdata[SR_PFAIL]
                                           | cyc_rdata[SR_EFAIL]; // R2
                        if (cyc_rdata[SR_SUPPLY]) begin
                            next_lock           = 1'b1; // R1
                            irq_set[IRQ_LOCK]   = 1'b1;
                        end
                        next_seq_err = (op_q == OP_ERASE) && cyc_rdata[SR_PFAIL]
                                       && cyc_rdata[SR_EFAIL]; // R15
                    end
                    next_state = S_WR_ARRAY; // R7
                end
            end
            S_WR_CMD: begin
                if (cyc_done) begin
                    if (op_q == OP_CLEAR) begin
                        next_lock    = 1'b0; // R1
                        next_seq_err = 1'b0;
                        next_state   = S_WR_ARRAY;
                    end else begin
                        next_state = S_RD_STAT;
                    end
                end
            end
            S_WR_ARRAY: begin
                if (cyc_done) begin
                    irq_set[IRQ_DONE] = 1'b1;
                    next_state        = S_IDLE;
                end
            end
            S_RD_ARRAY: begin
                if (cyc_done) begin
                    next_rbyte        = cyc_rdata;
                    irq_set[IRQ_DONE] = 1'b1;
                    next_state        = S_IDLE;
                end
            end
            S_PD_HOLD: begin
                if (cnt != 8'h00) begin
                    next_cnt = cnt - 8'h01;
                end else if (!pwr_req) begin
                    next_cnt   = WAKE_CYC;
                    next_state = S_WAKE;
                end
            end
            S_WAKE: begin
                if (cnt != 8'h00) begin
                    next_cnt = cnt - 8'h01; // R12
                end else if (ready_busy_n_i) begin // R3
                    next_dev_stat = SR_RESET; // R4
                    next_lock     = 1'b0;
                    next_seq_err  = 1'b0;
                    next_state    = S_IDLE; // R6
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        if (cyc_abort) begin
            irq_set[IRQ_ABORT] = op_live; // R11
            next_pend          = 1'b0;
            next_cnt           = RST_LOW_CYC;
            next_state         = S_PD_HOLD; // R10
        end
        next_pin_n = (next_state != S_PD_HOLD);
    end

    // Operation sequencer registers
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state               <= S_PD_HOLD;
            op_q                <= OP_READ;
            cnt                 <= RST_LOW_CYC;
            pend                <= 1'b0;
            lock                <= 1'b0;
            seq_err             <= 1'b0;
            dev_stat            <= SR_RESET;
            rbyte               <= 8'h00;
            powerdown_reset_n_o <= 1'b0;
        end else begin
            state               <= next_state;
            op_q                <= next_op;
            cnt                 <= next_cnt;
            pend                <= next_pend;
            lock                <= next_lock;
            seq_err             <= next_seq_err;
            dev_stat            <= next_dev_stat;
            rbyte               <= next_rbyte;
            powerdown_reset_n_o <= next_pin_n;
        end
    end

    // Register file next values
    always_comb begin
        next_addr   = addr_r;
        next_wdata  = wdata_r;
        next_pwr    = pwr_req;
        next_mask   = irq_mask;
        next_irq_st = irq_st;
        next_rdata  = 32'h00000000;
        if (reg_wr_i) begin
            case (reg_addr_i)
                REG_ADDR:     next_addr = reg_wdata_i[19:0];
                REG_WDATA:    next_wdata = reg_wdata_i[7:0];
                REG_PWR:      next_pwr = reg_wdata_i[0];
                REG_IRQ_MASK: next_mask = reg_wdata_i[IRQ_W-1:0];
                REG_IRQ_ST:   next_irq_st = irq_st & ~reg_wdata_i[IRQ_W-1:0];
                default:      next_addr = addr_r;
            endcase
        end
        next_irq_st = next_irq_st | irq_set; // Set beats clear
        if (reg_rd_i) begin
            case (reg_addr_i)
                REG_ADDR:     next_rdata = {12'h000, addr_r};
                REG_WDATA:    next_rdata = {24'h000000, wdata_r};
                REG_RDATA:    next_rdata = {24'h000000, rbyte};
                REG_DEVSTAT:  next_rdata = {24'h000000, dev_stat};
                REG_STATE:    next_rdata = {27'h0000000, ready_busy_n_i, seq_err,
                                            !powerdown_reset_n_o, lock, state != S_IDLE};
                REG_IRQ_ST:   next_rdata = {27'h0000000, irq_st};
                REG_IRQ_MASK: next_rdata = {27'h0000000, irq_mask};
                REG_PWR:      next_rdata = {31'h00000000, pwr_req};
                default:      next_rdata = 32'h00000000;
            endcase
        end
    end

    // Register file registers
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            addr_r      <= 20'h00000;
            wdata_r     <= 8'h00;
            pwr_req     <= 1'b0;
            irq_mask    <= IRQ_RESET;
            irq_st      <= IRQ_RESET;
            reg_rdata_o <= 32'h00000000;
            irq_o       <= 1'b0;
        end else begin
            addr_r      <= next_addr;
            wdata_r     <= next_wdata;
            pwr_req     <= next_pwr;
            irq_mask    <= next_mask;
            irq_st      <= next_irq_st;
            reg_rdata_o <= next_rdata;
            irq_o       <= |(next_irq_st & next_mask);
        end
    end

    // Checks on the pin protocol and sequencing
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n);

    strobe_pair_a: assert property (!flash_o.we_n |-> !flash_o.ce_n && flash_o.oe_n) // R8
        else $error("write strobe low without chip-select or with output enable");
    pd_quiet_a: assert property (!powerdown_reset_n_o |-> // R10
            flash_o.ce_n && flash_o.we_n && flash_o.oe_n && !flash_o.doe)
        else $error("flash controls active while reset pin low");
    wake_wait_a: assert property ($rose(powerdown_reset_n_o) |-> flash_o.ce_n [*8]) // R12
        else $error("chip-select low too soon after reset release");
    lock_refuse_a: assert property ((state == S_IDLE) && cmd_go && lock && !pwr_req // R1
            && ((reg_wdata_i[2:0] == OP_PROG) || (reg_wdata_i[2:0] == OP_ERASE))
            |=> (state == S_IDLE) && irq_st[IRQ_REFUSE])
        else $error("program or erase started while locked");
    clear_unlock_a: assert property ((state == S_WR_CMD) && (op_q == OP_CLEAR) && cyc_done // R1
            && !pwr_req |=> !lock)
        else $error("lock not cleared by clear-status");
    array_restore_a: assert property ((state == S_RD_STAT) && cyc_done // R7
            && cyc_rdata[SR_READY] && !pwr_req |=> (state == S_WR_ARRAY))
        else $error("read-array not written after status");
    abort_flag_a: assert property (pwr_req && op_live |=> irq_st[IRQ_ABORT]) // R11
        else $error("aborted operation not flagged");
    busy_hold_a: assert property ((state == S_WAIT_RDY) && !ready_busy_n_i // R13
            |=> (state == S_WAIT_RDY) || (state == S_PD_HOLD))
        else $error("status read while device busy");

    prog_done_c: cover property ((state == S_WR_ARRAY) && cyc_done && (op_q == OP_PROG));
    lock_hit_c: cover property (irq_set[IRQ_LOCK]);
    wake_end_c: cover property ((state == S_WAKE) ##1 (state == S_IDLE));
    poll_c: cover property ((state == S_RD_STAT) && cyc_done && !cyc_rdata[SR_READY]);
endmodule

// ---- bench/fcp_flash_model.sv ----
// Behavioural flash device answering the controller pins
module fcp_flash_model (
    input  wire logic          clk_i,
    input  fcp_pkg::fcp_pins_s pins_i,
    input  wire logic          pd_n_i,
    input  wire logic [7:0]    fail_i,
    output logic [7:0]         data_o,
    output logic               rb_n_o,
    output logic [7:0]         mem_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import fcp_pkg::*;
    logic [7:0] sr;
    logic [7:0] cmd;
    logic [7:0] last;
    logic       ce_q;
    logic       we_q;
    logic       st_md;
    int         busy = 0;
    // Command latch on strobe release, reset pin blocks it and cuts busy to at most 4 cycles
    always @(posedge clk_i) begin
        ce_q <= pins_i.ce_n;
        we_q <= pins_i.we_n;
        if (!pins_i.ce_n && !pins_i.oe_n) last <= data_o;
        if (!pd_n_i) begin
            sr <= SR_RESET;
            st_md <= 1'b0;
            if (busy > 4) busy <= 4;
            else if (busy > 0) busy <= busy - 1;
        end else if (busy > 0) begin
            busy <= busy - 1;
            if (busy == 1) sr <= SR_RESET | fail_i;
        end else if (!ce_q && !we_q && pins_i.we_n) begin
            cmd <= pins_i.dout;
            st_md <= pins_i.dout != CMD_ARRAY;
            if (pins_i.dout == CMD_CLEAR) sr <= SR_RESET;
            if ((cmd == CMD_PROG || (cmd == CMD_ERASE && pins_i.dout == CMD_CONFIRM))
                && !sr[SR_SUPPLY]) begin
                mem_o <= (cmd == CMD_PROG) ? pins_i.dout : 8'hff;
                busy <= 40;
                sr[SR_READY] <= 1'b0;
            end
        end
    end
    // Busy pin and data bus, released bus shows inverted last value
    assign rb_n_o = busy == 0;
    assign data_o = (!pins_i.ce_n && !pins_i.oe_n && pd_n_i) ?
                    (st_md ? (sr & SR_USED_MASK) : mem_o) : ~last;
endmodule

// ---- bench/flash_command_status_protection_bench.sv ----
// Self-checking bench of the flash controller with a device model
module flash_command_status_protection_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import fcp_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [31:0] reg_rdata_o;
    logic [31:0] rv;
    logic [7:0]  fail = 8'h00;
    logic [7:0]  fdata;
    logic [7:0]  mem;
    logic        irq_o;
    logic        rb_n;
    logic        pd_n;
    fcp_pins_s   flash_o;
    int          num_errors = 0;
    int          checks = 0;
    // Clock, design and device
    always #2 clk_sys_i = ~clk_sys_i;
    fcp_top uut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .flash_o(flash_o), .flash_data_i(fdata),
        .ready_busy_n_i(rb_n), .powerdown_reset_n_o(pd_n));
    fcp_flash_model dev (.clk_i(clk_sys_i), .pins_i(flash_o), .pd_n_i(pd_n),
        .fail_i(fail), .data_o(fdata), .rb_n_o(rb_n), .mem_o(mem));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Bus cycles: one strobe cycle each, read data one cycle later
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 rv = reg_rdata_o;
    endtask
    // Poll until idle with the flash awake
    task automatic settle();
        for (int n = 0; n < 2000; n++) begin
            rd(REG_STATE);
            if (rv[0] === 1'b0 && pd_n === 1'b1) break;
        end
        wr(REG_IRQ_ST, 32'h1f);
    endtask
    task automatic wait_irq(input logic [4:0] m, input logic [31:0] exp);
        wr(REG_IRQ_MASK, 32'(m));
        for (int n = 0; n < 9000 && irq_o !== 1'b1; n++) @(posedge clk_sys_i);
        rd(REG_IRQ_ST);
        check("irq_st", rv, exp);
        wr(REG_IRQ_ST, 32'h1f);
        @(posedge clk_sys_i);
        #1 check("irq_clr", 32'(irq_o), 32'h0);
    endtask
    task automatic prog(input logic [7:0] d);
        wr(REG_ADDR, 32'h12345);
        wr(REG_WDATA, 32'(d));
        wr(REG_CMD, 32'(OP_PROG));
    endtask
    task automatic t_reset();
        settle();
        rd(REG_DEVSTAT);
        check("devstat_rst", rv, 32'h80);
        rd(REG_IRQ_MASK);
        check("mask_rst", rv, 32'h0);
    endtask
    task automatic t_prog();
        prog(8'h5a);
        wait_irq(5'h01, 32'h01);
        check("mem_prog", 32'(mem), 32'h5a);
        rd(REG_DEVSTAT);
        check("devstat_ok", rv, 32'h80);
        wr(REG_CMD, 32'(OP_READ));
        settle();
        rd(REG_RDATA);
        check("array_rd", rv, 32'h5a);
    endtask
    task automatic t_fail();
        fail <= 8'h30;
        wr(REG_CMD, 32'(OP_ERASE));
        wait_irq(5'h01, 32'h03);
        rd(REG_DEVSTAT);
        check("devstat_fail", rv, 32'hb0);
        rd(REG_STATE);
        check("seq_err", 32'(rv[3]), 32'h1);
        fail <= 8'h00;
        wr(REG_CMD, 32'(OP_CLEAR));
        settle();
        wr(REG_CMD, 32'(OP_STATUS));
        settle();
        rd(REG_DEVSTAT);
        check("devstat_clr", rv, 32'h80);
    endtask
    task automatic t_lock();
        fail <= 8'h08;
        prog(8'h11);
        wait_irq(5'h01, 32'h07);
        fail <= 8'h00;
        prog(8'h22);
        wait_irq(5'h08, 32'h08);
        check("mem_kept", 32'(mem), 32'h11);
        wr(REG_CMD, 32'(OP_CLEAR));
        settle();
        prog(8'h3c);
        wait_irq(5'h01, 32'h01);
        check("mem_retry", 32'(mem), 32'h3c);
    endtask
    task automatic t_abort();
        prog(8'h77);
        for (int n = 0; n < 500 && rb_n !== 1'b0; n++) @(posedge clk_sys_i);
        wr(REG_PWR, 32'h1);
        wait_irq(5'h10, 32'h10);
        check("pd_pin", 32'(pd_n), 32'h0);
        wr(REG_PWR, 32'h0);
        settle();
        rd(REG_DEVSTAT);
        check("devstat_wake", rv, 32'h80);
    endtask
    // Watchdog and main sequence
    initial begin
        repeat (50000) @(posedge clk_sys_i);
        num_errors++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_prog();
        t_fail();
        t_lock();
        t_abort();
        finish_test();
    end
endmodule
